// ===== design/pmm_pkg.sv
`default_nettype none
package pmm_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT1_CTRL = 8'h1d;
  localparam logic [7:0] IDX_PORT2_CTRL = 8'h2d;
  localparam logic [7:0] IDX_MODE_CTRL  = 8'hc3;
  localparam logic [7:0] IDX_SLEEP_TIME = 8'hc4;
  localparam logic [7:0] IDX_STATUS     = 8'hc5;

  // bus geometry
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam int REG_W  = 8;

  // field positions
  localparam int PORT_PD_BIT  = 3;
  localparam int MODE_LSB     = 0;
  localparam int PLL_DIS_BIT  = 2;
  localparam int ST_EDLOW_BIT = 2;
  localparam int ST_PLL_BIT   = 3;
  localparam int ST_RXP_LSB   = 4;
  localparam int ST_MAC_BIT   = 6;

  // power mode encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ED     = 2'h1;
  localparam logic [1:0] MODE_SPD    = 2'h2;
  localparam logic [1:0] MODE_PS     = 2'h3;

  // reset values
  localparam logic [REG_W-1:0] RST_PORT  = 8'h00;
  localparam logic [REG_W-1:0] RST_MODE  = 8'h00;
  localparam logic [REG_W-1:0] RST_SLEEP = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int PULSE_WIDTH_NS  = 120;
  localparam int PULSE_PERIOD_S  = 1;
  localparam int SLEEP_STEP_MS   = 1;
  localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_S * (1000000000 / CLK_PERIOD_NS);
  localparam int SLEEP_STEP_CYC  = SLEEP_STEP_MS * (1000000 / CLK_PERIOD_NS);
  localparam int CNT_W           = 26;
  localparam int IDLE_W          = 9;

  // energy detect sub-states
  typedef enum logic {ED_NORMAL, ED_LOW} pmm_ed_state_t;

  // power enables toward the chip
  typedef struct packed {
    logic       pll_en;       // internal pll clocks running
    logic       mac_en;       // mac powered
    logic       host_if_en;   // host interface nominally enabled
    logic       rx_ed_en;     // receiver energy detector on
    logic [1:0] phy_tx_en;    // per-port transmitter on
    logic [1:0] phy_rx_en;    // per-port receiver fully on
    logic [1:0] rx_partial;   // per-port unused receiver sections off
  } pmm_ctrl_t;

endpackage
`default_nettype wire

// ===== design/pmm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pmm_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst_n,    // synchronous reset, active low
  input  wire logic [W-1:0] async_i,  // pin level from outside the domain
  output logic      [W-1:0] level_q   // filtered level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // three stages; s1 is read by s2 only, so metastability stays contained
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/pmm_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module pmm_pulse
  import pmm_pkg::*;
#(
  parameter int PERIOD_CYC = 40000000,
  parameter int WIDTH_CYC  = 5
) (
  input  wire logic clk,      // system clock
  input  wire logic rst_n,    // synchronous reset, active low
  input  wire logic run,      // emit pulses while high
  output logic      pulse_q   // link pulse, registered
);
  import pmm_pkg::*;

  logic [CNT_W-1:0] cnt_q;

  // free period counter; restarts whenever run drops so the first pulse is prompt
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_q <= '0;
    end else if (cnt_q == CNT_W'(PERIOD_CYC - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // pulse high for the first WIDTH_CYC counts of each period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= run && (cnt_q < CNT_W'(WIDTH_CYC));
    end
  end
endmodule
`default_nettype wire

// ===== design/pmm_top.sv
// How it works
// - two-bit mode field picks normal, energy detect, soft power down or power saving
// - port control bit 3 powers down only that port's phy
// - mode field resets to normal
// - normal mode runs pll, phy, mac and host interface
// - from normal, writing the mode field moves straight to any mode
// - power saving acts only with mode 11, autoneg on, no cable
// - power saving keeps pll, mac, host, transmitter; drops unused receiver parts
// - link activity in power saving restores full phy power
// - from power saving, writing the mode field moves to the new mode
// - energy detect has normal and low states; low keeps only energy detector and pll
// - no cable energy longer than sleep delay enters low state
// - cable energy in low state returns to normal power state
// - low state emits 120 ns link pulses once per second; the width rounds up to 5 cycles, 125 ns
// - in the energy detect low state, mode bit 2 disables the pll
// - soft power down stops pll, phy and mac, keeps registers
// - writing 00 during soft power down returns to normal
`timescale 1ns/1ps
`default_nettype none
module pmm_top
  import pmm_pkg::*;
#(
  parameter int PULSE_PERIOD = PULSE_PERIOD_CYC,
  parameter int SLEEP_STEP   = SLEEP_STEP_CYC
) (
  input  wire logic                  aclk,          // system clock, 40 MHz
  input  wire logic                  aresetn,       // synchronous reset, active low
  input  wire logic [AXI_AW-1:0]     s_awaddr,      // write address
  input  wire logic                  s_awvalid,     // write address valid
  output logic                       s_awready,     // write address ready
  input  wire logic [AXI_DW-1:0]     s_wdata,       // write data
  input  wire logic [AXI_DW/8-1:0]   s_wstrb,       // write byte strobes
  input  wire logic                  s_wvalid,      // write data valid
  output logic                       s_wready,      // write data ready
  output logic [1:0]                 s_bresp,       // write response
  output logic                       s_bvalid,      // write response valid
  input  wire logic                  s_bready,      // write response ready
  input  wire logic [AXI_AW-1:0]     s_araddr,      // read address
  input  wire logic                  s_arvalid,     // read address valid
  output logic                       s_arready,     // read address ready
  output logic [AXI_DW-1:0]          s_rdata,       // read data
  output logic [1:0]                 s_rresp,       // read response
  output logic                       s_rvalid,      // read data valid
  input  wire logic                  s_rready,      // read data ready
  input  wire logic [1:0]            rx_energy_i,   // per-port cable energy pin
  input  wire logic [1:0]            link_act_i,    // per-port link activity pin
  input  wire logic [1:0]            an_enable,     // per-port autoneg enabled, same clock
  output pmm_ctrl_t                  pwr_ctrl,      // registered power enables
  output logic [1:0]                 link_pulse     // per-port low-state link pulses
);
  import pmm_pkg::*;

  // register file
  logic [REG_W-1:0] port1_q;
  logic [REG_W-1:0] port2_q;
  logic [REG_W-1:0] mode_ctrl_q;
  logic [REG_W-1:0] sleep_q;
  logic [1:0]       mode_q;
  assign mode_q = mode_ctrl_q[MODE_LSB +: 2];

  // axi write side
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [AXI_DW-1:0] wdata_q;
  logic              wstrb0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              do_write;
  logic [7:0]        w_idx;
  logic              w_mapped;

  // axi read side
  logic              rvalid_q;
  logic [AXI_DW-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic [7:0]        r_idx;

  // synchronised pins and state
  logic [1:0]       energy_s;
  logic [1:0]       act_s;
  logic             energy_any;
  pmm_ed_state_t    ed_state_q;
  logic [CNT_W-1:0] step_q;
  logic [IDLE_W-1:0] idle_q;
  logic             step_tick;
  pmm_ctrl_t        ctrl_q;
  pmm_ctrl_t        ctrl_d;
  logic [1:0]       port_pd;
  logic [1:0]       ps_low;

  // pin inputs cross into aclk through three stages
  pmm_sync #(.W(2)) u_sync_energy (
    .clk     (aclk),
    .rst_n   (aresetn),
    .async_i (rx_energy_i),
    .level_q (energy_s)
  );

  pmm_sync #(.W(2)) u_sync_act (
    .clk     (aclk),
    .rst_n   (aresetn),
    .async_i (link_act_i),
    .level_q (act_s)
  );

  // the bus is never gated by the mode, so a stuck low-power state cannot lock software out
  assign s_awready = !aw_hold_q && !bvalid_q;
  assign s_wready  = !w_hold_q && !bvalid_q;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;
  assign s_arready = !rvalid_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign w_idx    = awaddr_q[9:2];
  assign r_idx    = s_araddr[9:2];
  assign w_mapped = (awaddr_q[AXI_AW-1:10] == '0) &&
                    ((w_idx == IDX_PORT1_CTRL) || (w_idx == IDX_PORT2_CTRL) ||
                     (w_idx == IDX_MODE_CTRL)  || (w_idx == IDX_SLEEP_TIME) ||
                     (w_idx == IDX_STATUS));

  // address and data are held independently; either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_wdata;
        wstrb0_q <= s_wstrb[0];
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // register writes; only byte lane 0 carries data, status is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port1_q     <= RST_PORT;
      port2_q     <= RST_PORT;
      mode_ctrl_q <= RST_MODE;
      sleep_q     <= RST_SLEEP;
    end else if (do_write && w_mapped && wstrb0_q) begin
      case (w_idx)
        IDX_PORT1_CTRL: port1_q <= wdata_q[REG_W-1:0];
        IDX_PORT2_CTRL: port2_q <= wdata_q[REG_W-1:0];
        IDX_MODE_CTRL:  mode_ctrl_q <= wdata_q[REG_W-1:0];
        IDX_SLEEP_TIME: sleep_q <= wdata_q[REG_W-1:0];
        default: ;
      endcase
    end
  end

  // read path answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
      if (s_araddr[AXI_AW-1:10] != '0) begin
        rresp_q <= RESP_SLVERR;
      end else begin
        case (r_idx)
          IDX_PORT1_CTRL: rdata_q[REG_W-1:0] <= port1_q;
          IDX_PORT2_CTRL: rdata_q[REG_W-1:0] <= port2_q;
          IDX_MODE_CTRL:  rdata_q[REG_W-1:0] <= mode_ctrl_q;
          IDX_SLEEP_TIME: rdata_q[REG_W-1:0] <= sleep_q;
          IDX_STATUS: begin
            rdata_q[MODE_LSB +: 2]   <= mode_q;
            rdata_q[ST_EDLOW_BIT]    <= (ed_state_q == ED_LOW);
            rdata_q[ST_PLL_BIT]      <= ctrl_q.pll_en;
            rdata_q[ST_RXP_LSB +: 2] <= ctrl_q.rx_partial;
            rdata_q[ST_MAC_BIT]      <= ctrl_q.mac_en;
          end
          default: rresp_q <= RESP_SLVERR;
        endcase
      end
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign energy_any = |energy_s;
  assign step_tick  = (step_q == CNT_W'(SLEEP_STEP - 1));

  // sleep-delay step prescaler; restarts on energy so idle time is measured cleanly
  always_ff @(posedge aclk) begin
    if (!aresetn || energy_any || mode_q != MODE_ED || step_tick) begin
      step_q <= '0;
    end else begin
      step_q <= step_q + CNT_W'(1);
    end
  end

  // idle time in steps, saturating so a long quiet cable never wraps back
  always_ff @(posedge aclk) begin
    if (!aresetn || energy_any || mode_q != MODE_ED) begin
      idle_q <= '0;
    end else if (step_tick && idle_q != '1) begin
      idle_q <= idle_q + IDLE_W'(1);
    end
  end

  // energy detect sleep and wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ed_state_q <= ED_NORMAL;
    end else if (mode_q != MODE_ED) begin
      ed_state_q <= ED_NORMAL;
    end else begin
      case (ed_state_q)
        ED_NORMAL: if (!energy_any && idle_q > {1'b0, sleep_q}) begin
          ed_state_q <= ED_LOW;
        end
        ED_LOW: if (energy_any) begin
          ed_state_q <= ED_NORMAL;
        end
        default: ed_state_q <= ED_NORMAL;
      endcase
    end
  end

  assign port_pd = {port2_q[PORT_PD_BIT], port1_q[PORT_PD_BIT]};
  // receiver trim only with autoneg on, no cable and no link attempt
  assign ps_low  = {2{mode_q == MODE_PS}} & an_enable & ~energy_s & ~act_s;

  // power enables from mode, sub-state and per-port power down
  always_comb begin
    ctrl_d = '0;
    case (mode_q)
      MODE_NORMAL: begin
        ctrl_d.pll_en     = 1'b1;
        ctrl_d.mac_en     = 1'b1;
        ctrl_d.host_if_en = 1'b1;
        ctrl_d.phy_tx_en  = 2'b11;
        ctrl_d.phy_rx_en  = 2'b11;
      end
      MODE_PS: begin
        ctrl_d.pll_en     = 1'b1;
        ctrl_d.mac_en     = 1'b1;
        ctrl_d.host_if_en = 1'b1;
        ctrl_d.phy_tx_en  = 2'b11;
        ctrl_d.phy_rx_en  = ~ps_low;
        ctrl_d.rx_partial = ps_low;
      end
      MODE_ED: begin
        ctrl_d.rx_ed_en = 1'b1;
        if (ed_state_q == ED_NORMAL) begin
          ctrl_d.pll_en     = 1'b1;
          ctrl_d.mac_en     = 1'b1;
          ctrl_d.host_if_en = 1'b1;
          ctrl_d.phy_tx_en  = 2'b11;
          ctrl_d.phy_rx_en  = 2'b11;
        end else begin
          ctrl_d.pll_en = !mode_ctrl_q[PLL_DIS_BIT];
        end
      end
      MODE_SPD: ctrl_d = '0;
      default: ctrl_d = '0;
    endcase
    ctrl_d.phy_tx_en  = ctrl_d.phy_tx_en & ~port_pd;
    ctrl_d.phy_rx_en  = ctrl_d.phy_rx_en & ~port_pd;
    ctrl_d.rx_partial = ctrl_d.rx_partial & ~port_pd;
  end

  // enables leave through flops so the power switches see no glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  assign pwr_ctrl = ctrl_q;

  // one generator per port, running only in the low state of a powered port
  for (genvar p = 0; p < 2; p++) begin : g_pulse
    pmm_pulse #(.PERIOD_CYC(PULSE_PERIOD), .WIDTH_CYC(PULSE_WIDTH_CYC)) u_pulse (
      .clk     (aclk),
      .rst_n   (aresetn),
      .run     ((ed_state_q == ED_LOW) && !port_pd[p]),
      .pulse_q (link_pulse[p])
    );
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_mode_a: assert property (disable iff (1'b0) !aresetn |=> mode_ctrl_q[1:0] == MODE_NORMAL)
    else $error("mode field not normal after reset");
  mode_write_a: assert property (do_write && w_mapped && wstrb0_q && w_idx == IDX_MODE_CTRL
      |=> mode_q == $past(wdata_q[1:0]))
    else $error("mode write not applied");
  // the release edge still has the enables cleared, so an attempt there must not count
  normal_on_a: assert property (aresetn && mode_q == MODE_NORMAL && port_pd == 2'b00
      ##1 mode_q == MODE_NORMAL
      |-> ctrl_q.pll_en && ctrl_q.mac_en && ctrl_q.phy_rx_en == 2'b11)
    else $error("normal mode not fully powered");
  spd_off_a: assert property (mode_q == MODE_SPD |=> !ctrl_q.pll_en && !ctrl_q.mac_en
      && ctrl_q.phy_tx_en == 2'b00 && !ctrl_q.host_if_en)
    else $error("soft power down left blocks on");
  port_pd_a: assert property (port_pd[1] |=> ctrl_q.phy_tx_en[1] == 1'b0)
    else $error("port power down ignored");
  ps_trim_a: assert property (ctrl_q.rx_partial[0] |-> ctrl_q.phy_tx_en[0] && ctrl_q.pll_en
      && ctrl_q.mac_en && $past(mode_q) == MODE_PS && $past(an_enable[0]))
    else $error("power saving trim in wrong conditions");
  ps_wake_a: assert property (mode_q == MODE_PS && act_s[0] && !port_pd[0]
      |=> ctrl_q.phy_rx_en[0])
    else $error("activity did not restore receiver");
  ed_sleep_a: assert property (ed_state_q == ED_NORMAL ##1 ed_state_q == ED_LOW
      |-> $past(idle_q) > {1'b0, $past(sleep_q)})
    else $error("entered low state too early");
  ed_wake_a: assert property (ed_state_q == ED_LOW && energy_any && mode_q == MODE_ED
      |=> ed_state_q == ED_NORMAL)
    else $error("energy did not wake device");
  pulse_width_a: assert property ($rose(link_pulse[0]) |-> link_pulse[0] [*5] ##1 !link_pulse[0])
    else $error("link pulse width wrong");
  pll_dis_a: assert property (ed_state_q == ED_LOW && mode_q == MODE_ED
      && mode_ctrl_q[PLL_DIS_BIT] |=> !ctrl_q.pll_en)
    else $error("pll not disabled");

  ed_low_c: cover property (ed_state_q == ED_NORMAL ##1 ed_state_q == ED_LOW);
  spd_back_c: cover property (mode_q == MODE_SPD ##[1:20] mode_q == MODE_NORMAL);
  ps_trim_c: cover property (ctrl_q.rx_partial != 2'b00 ##[1:20] ctrl_q.rx_partial == 2'b00);
endmodule
`default_nettype wire

// ===== testbench/pmm_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// cable side of both ports; pins move 7 ns after the edge so they are
// truly asynchronous to the block and must pass its synchronisers
module pmm_line_model (
  input  wire logic       aclk,      // system clock
  input  wire logic [1:0] plugged,   // cable with live energy attached
  input  wire logic [1:0] far_try,   // far end tries to bring link up
  output logic      [1:0] energy,    // cable energy pin
  output logic      [1:0] activity   // link activity pin
);
  // no hold beyond the command: a dropped cable clears energy at once;
  // the pins settle on the first edge, well inside the block's reset
  always @(posedge aclk) begin
    energy <= #7 plugged;
    activity <= #7 far_try;
  end
endmodule
`default_nettype wire

// ===== testbench/power_mode_manager_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_mode_manager_bench;
  import pmm_pkg::*;
  localparam int PP = 200;
  localparam int SS = 4;
  localparam logic [11:0] A_P1 = {2'h0, IDX_PORT1_CTRL, 2'h0};
  localparam logic [11:0] A_P2 = {2'h0, IDX_PORT2_CTRL, 2'h0};
  localparam logic [11:0] A_MD = {2'h0, IDX_MODE_CTRL, 2'h0};
  localparam logic [11:0] A_SL = {2'h0, IDX_SLEEP_TIME, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, IDX_STATUS, 2'h0};
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_awaddr = '0, s_araddr = '0;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [31:0] s_wdata = '0, s_rdata, d;
  logic [3:0]  s_wstrb = '0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, rx_energy, link_act, link_pulse, r;
  logic [1:0]  an_enable = '0, plugged = '0, far_try = '0;
  pmm_ctrl_t   pwr_ctrl;
  int          fail_count = 0, n_checks = 0, n, c0, c1;

  always #12.5 aclk = ~aclk;

  pmm_top #(.PULSE_PERIOD(PP), .SLEEP_STEP(SS)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .rx_energy_i(rx_energy),
    .link_act_i(link_act), .an_enable(an_enable), .pwr_ctrl(pwr_ctrl),
    .link_pulse(link_pulse));

  pmm_line_model i_line (.aclk(aclk), .plugged(plugged), .far_try(far_try),
    .energy(rx_energy), .activity(link_act));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hung wait ends the run through the same report
  task automatic lost;
    fail_count++;
    $display("wrong value: wait limit, expected answer, seen none");
    give_verdict();
  endtask
  task automatic chk_val(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value: %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value: response expected %h seen %h", e, g);
    end
  endtask
  // sampled at the falling edge, where nothing the bench drives is moving
  function automatic logic [15:0] pw(input logic [15:0] m);
    return m & {6'h0, pwr_ctrl.pll_en, pwr_ctrl.mac_en, pwr_ctrl.host_if_en,
      pwr_ctrl.rx_ed_en, pwr_ctrl.phy_tx_en, pwr_ctrl.phy_rx_en, pwr_ctrl.rx_partial};
  endfunction
  // aw and w offered together, each dropped at its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
    logic ha, hw, hb;
    int k;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= {24'h0, v};
    s_wstrb <= 4'h1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    hb = 0;
    k = 0;
    while (!hb && k < 100) begin
      @(negedge aclk);
      ha = s_awvalid && s_awready;
      hw = s_wvalid && s_wready;
      hb = s_bvalid;
      r = s_bresp;
      @(posedge aclk);
      k++;
      if (ha) s_awvalid <= 1'b0;
      if (hw) s_wvalid <= 1'b0;
      if (hb) s_bready <= 1'b0;
    end
    if (!hb) lost();
    chk_resp(er, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    logic ha, hr;
    int k;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    hr = 0;
    k = 0;
    while (!hr && k < 100) begin
      @(negedge aclk);
      ha = s_arvalid && s_arready;
      hr = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge aclk);
      k++;
      if (ha) s_arvalid <= 1'b0;
      if (hr) s_rready <= 1'b0;
    end
    if (!hr) lost();
    chk_resp(er, r);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic pins(input logic [1:0] pl, input logic [1:0] ft, input logic [1:0] an);
    @(posedge aclk);
    plugged <= pl;
    far_try <= ft;
    an_enable <= an;
  endtask
  task automatic wait_mac(input logic v);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (pwr_ctrl.mac_en !== v && n < 300);
    if (pwr_ctrl.mac_en !== v) lost();
  endtask
  task automatic count_pulses;
    c0 = 0;
    c1 = 0;
    repeat (2 * PP) begin
      @(negedge aclk);
      c0 += int'(link_pulse[0]);
      c1 += int'(link_pulse[1]);
    end
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    settle(3);
    rd(A_MD, RESP_OKAY);
    chk_val("mode", 16'h0, d[15:0]);
    chk_val("normal", 16'h3bc, pw(16'h3bc));
    // stored registers: reset to zero, then read back what was written
    for (int i = 0; i < 3; i++) begin
      rd(i == 0 ? A_P1 : i == 1 ? A_P2 : A_SL, RESP_OKAY);
      chk_val("reg reset", 16'h0, d[15:0]);
      wr(i == 0 ? A_P1 : i == 1 ? A_P2 : A_SL, 8'ha4 + 8'(i), RESP_OKAY);
      rd(i == 0 ? A_P1 : i == 1 ? A_P2 : A_SL, RESP_OKAY);
      chk_val("reg rw", 16'h00a4 + 16'(i), d[15:0]);
    end
    wr(12'h000, 8'h01, RESP_SLVERR);
    rd(12'h000, RESP_SLVERR);
    chk_val("unmapped", 16'h0, d[15:0]);
    wr(A_ST, 8'hff, RESP_OKAY);
    rd(A_MD, RESP_OKAY);
    chk_val("mode", 16'h0, d[15:0]);
    // per-port power down leaves the other port and the chip mode alone
    wr(A_P1, 8'h08, RESP_OKAY);
    settle(3);
    chk_val("port1 down", 16'h3a8, pw(16'h3bc));
    wr(A_P2, 8'h08, RESP_OKAY);
    settle(3);
    chk_val("both down", 16'h380, pw(16'h3bc));
    wr(A_P1, 8'h00, RESP_OKAY);
    wr(A_P2, 8'h00, RESP_OKAY);
    wr(A_MD, {6'h0, MODE_SPD}, RESP_OKAY);
    settle(3);
    chk_val("soft down", 16'h0, pw(16'h3bc));
    rd(A_SL, RESP_OKAY);
    chk_val("kept", 16'h00a6, d[15:0]);
    rd(A_ST, RESP_OKAY);
    chk_val("status", 16'h02, d[15:0] & 16'h4b);
    wr(A_MD, {6'h0, MODE_NORMAL}, RESP_OKAY);
    settle(3);
    chk_val("back normal", 16'h3bc, pw(16'h3bc));
    // power saving trims receivers only while idle with autoneg on
    pins(2'h0, 2'h0, 2'h3);
    wr(A_MD, {6'h0, MODE_PS}, RESP_OKAY);
    settle(8);
    chk_val("saving", 16'h3b3, pw(16'h3b3));
    pins(2'h0, 2'h1, 2'h3);
    settle(8);
    chk_val("far try", 16'h3b2, pw(16'h3b3));
    pins(2'h2, 2'h0, 2'h3);
    settle(8);
    chk_val("plug", 16'h3b1, pw(16'h3b3));
    pins(2'h0, 2'h0, 2'h2);
    settle(8);
    chk_val("no autoneg", 16'h3b2, pw(16'h3b3));
    // energy detect: sleep after the delay, pulse, wake on energy
    wr(A_SL, 8'h03, RESP_OKAY);
    wr(A_MD, {6'h0, MODE_ED}, RESP_OKAY);
    wait_mac(1'b0);
    chk_val("sleep late", 16'h1, 16'(n >= 3 * SS));
    chk_val("low state", 16'h240, pw(16'h3ff));
    count_pulses();
    chk_val("pulses", 16'(4 * PULSE_WIDTH_CYC), 16'(c0 + c1));
    wr(A_MD, {5'h0, 1'b1, MODE_ED}, RESP_OKAY);
    settle(3);
    chk_val("pll off", 16'h040, pw(16'h3ff));
    pins(2'h1, 2'h0, 2'h3);
    wait_mac(1'b1);
    chk_val("wake", 16'h200, pw(16'h200));
    settle(10);
    count_pulses();
    chk_val("no pulses", 16'h0, 16'(c0 + c1));
    // a second reset in mid-run clears the stored registers
    wr(A_P1, 8'h55, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    settle(3);
    rd(A_P1, RESP_OKAY);
    chk_val("port1 reset", 16'h0, d[15:0]);
    rd(A_MD, RESP_OKAY);
    chk_val("mode reset", 16'h0, d[15:0]);
    give_verdict();
  end
endmodule
`default_nettype wire
